// >>> hw/twsm_top.sv
// Purpose: two-wire serial master/slave port with APB register access
// Assumes: pclk 125 MHz; bus lines open drain with pull-ups
// Notes: APB answers in the second access cycle; one bit engine serves both roles
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "twsm_cfg.svh"
module twsm_top #(
  parameter logic [21:0] LOWTO_CYC = 22'(`TWSM_LOWTO_CYC),
  parameter logic [12:0] FREE_CYC  = 13'(`TWSM_FREE_CYC)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);
  import twsm_pkg::*;

  localparam logic [9:0] HALF_CYC = 10'(`TWSM_HALF_CYC);

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  logic [2:0]  scl_sh_reg, scl_sh_next;
  logic [2:0]  sda_sh_reg, sda_sh_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  twsm_mst_t   mst_reg, mst_next;
  logic [9:0]  tcnt_reg, tcnt_next;
  logic        sclhi_reg, sclhi_next;
  logic        rs_reg, rs_next;
  logic        en_reg, en_next;
  logic        sta_reg, sta_next;
  logic        sto_reg, sto_next;
  logic        si_reg, si_next;
  logic        aa_reg, aa_next;
  logic        to_reg, to_next;
  logic        busy_reg, busy_next;
  logic [7:0]  own_reg, own_next;
  logic [7:0]  shift_reg, shift_next;
  logic [7:0]  stat_reg, stat_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic        tx_reg, tx_next;
  logic        addr_reg, addr_next;
  logic        eng_reg, eng_next;
  logic        ackd_reg, ackd_next;
  logic        ackok_reg, ackok_next;
  logic        arbl_reg, arbl_next;
  logic [21:0] lowc_reg, lowc_next;
  logic [12:0] freec_reg, freec_next;
  logic        scl_oe_reg, scl_oe_next;
  logic        sda_oe_reg, sda_oe_next;
  logic        scl_s, scl_p, sda_s, sda_p;
  logic        rise, fall, start_det, stop_det;
  logic        master_on, half_done, wr_en, acc, lowto_hit;

  // Bus view: only stage 1 and later of each synchroniser are used
  assign scl_s     = scl_sh_reg[1];
  assign scl_p     = scl_sh_reg[2];
  assign sda_s     = sda_sh_reg[1];
  assign sda_p     = sda_sh_reg[2];
  assign rise      = scl_s & ~scl_p;
  assign fall      = ~scl_s & scl_p;
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;
  assign master_on = (mst_reg != m_idle);
  assign half_done = (tcnt_reg == HALF_CYC - 10'h1);
  assign acc       = psel & penable & ~pready_reg;
  assign wr_en     = psel & penable & pready_reg & pwrite;
  assign lowto_hit = en_reg & ~scl_s & (lowc_reg == LOWTO_CYC - 22'h1);

  // Line synchronisers, reset to the idle-high bus level
  always_comb begin
    scl_sh_next = {scl_sh_reg[1:0], scl_i};
    sda_sh_next = {sda_sh_reg[1:0], sda_i};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sh_reg <= 3'h7;
      sda_sh_reg <= 3'h7;
    end else begin
      scl_sh_reg <= scl_sh_next;
      sda_sh_reg <= sda_sh_next;
    end
  end

  // APB read side; data and error are registered in the same cycle as pready
  always_comb begin
    pready_next  = acc;
    prdata_next  = prdata_reg;
    pslverr_next = 1'h0;
    if (acc) begin
      prdata_next  = 32'h0;
      pslverr_next = 1'h1;
      if (reg_hit(paddr, `TWSM_OFS_CTRL)) begin
        prdata_next  = {24'h0, busy_reg, en_reg, sta_reg, sto_reg, si_reg, aa_reg, 1'h0, to_reg};
        pslverr_next = 1'h0;
      end
      if (reg_hit(paddr, `TWSM_OFS_DATA)) begin
        prdata_next  = {24'h0, shift_reg};
        pslverr_next = 1'h0;
      end
      if (reg_hit(paddr, `TWSM_OFS_ADDR)) begin
        prdata_next  = {24'h0, own_reg};
        pslverr_next = 1'h0;
      end
      if (reg_hit(paddr, `TWSM_OFS_STAT)) begin
        prdata_next  = {24'h0, si_reg ? stat_reg : `TWSM_ST_IDLE};
        pslverr_next = 1'h0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'h0;
      pslverr_reg <= 1'h0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Protocol engine, master sequencer and control flags
  always_comb begin
    mst_next    = mst_reg;
    tcnt_next   = tcnt_reg;
    sclhi_next  = sclhi_reg;
    rs_next     = rs_reg;
    en_next     = en_reg;
    sta_next    = sta_reg;
    sto_next    = sto_reg;
    si_next     = si_reg;
    aa_next     = aa_reg;
    to_next     = to_reg;
    busy_next   = busy_reg;
    own_next    = own_reg;
    shift_next  = shift_reg;
    stat_next   = stat_reg;
    cnt_next    = cnt_reg;
    tx_next     = tx_reg;
    addr_next   = addr_reg;
    eng_next    = eng_reg;
    ackd_next   = ackd_reg;
    ackok_next  = ackok_reg;
    arbl_next   = arbl_reg;
    lowc_next   = 22'h0;
    freec_next  = 13'h0;
    // Software writes first so that hardware sets below win the same cycle
    if (wr_en && reg_hit(paddr, `TWSM_OFS_CTRL)) begin
      en_next  = pwdata[`TWSM_B_EN];
      sta_next = pwdata[`TWSM_B_STA];
      sto_next = pwdata[`TWSM_B_STO];
      si_next  = pwdata[`TWSM_B_SI];
      aa_next  = pwdata[`TWSM_B_AA];
      to_next  = pwdata[`TWSM_B_TO];
    end
    if (wr_en && reg_hit(paddr, `TWSM_OFS_ADDR))
      own_next = pwdata[7:0];
    if (wr_en && reg_hit(paddr, `TWSM_OFS_DATA))
      shift_next = pwdata[7:0];
    // Bus-free watch: idle-high time frees the bus without a STOP
    if (scl_s & sda_s & busy_reg) begin
      if (freec_reg == FREE_CYC - 13'h1)
        busy_next = 1'h0;
      else
        freec_next = freec_reg + 13'h1;
    end
    // Bit engine follows the observed clock for either role
    if (start_det) begin
      busy_next = 1'h1;
      cnt_next  = 4'hF; // First clock fall after START is not a bit; it wraps to 0
      addr_next = 1'h1;
      tx_next   = master_on;
      eng_next  = master_on;
      arbl_next = 1'h0;
      ackd_next = 1'h0;
    end else if (stop_det) begin
      busy_next = 1'h0;
      sto_next  = 1'h0;
      if (eng_reg & ~master_on) begin
        si_next   = 1'h1;
        stat_next = `TWSM_ST_SRSTOP;
      end
      eng_next  = 1'h0;
      tx_next   = 1'h0;
      addr_next = 1'h0;
      ackd_next = 1'h0;
    end else if (rise) begin
      if (cnt_reg < 4'h8) begin
        shift_next = {shift_reg[6:0], sda_s};
        if (tx_reg & ~sda_oe_reg & ~sda_s) begin
          arbl_next = 1'h1;
          tx_next   = 1'h0;
          eng_next  = 1'h0;
          mst_next  = m_idle;
        end
      end else begin
        ackok_next = ~sda_s;
      end
    end else if (fall) begin
      if (cnt_reg == 4'h7) begin
        cnt_next = 4'h8;
        if (addr_reg & ~master_on)
          ackd_next = aa_reg & ((shift_reg[7:1] == own_reg[7:1])
                    | ((shift_reg[7:1] == 7'h0) & own_reg[0]));
        else
          ackd_next = ~tx_reg & eng_reg & aa_reg;
      end else if (cnt_reg == 4'h8) begin
        cnt_next  = 4'h0;
        addr_next = 1'h0;
        if (master_on) begin
          si_next = 1'h1;
          if (addr_reg) begin
            tx_next = ~shift_reg[0];
            if (shift_reg[0])
              stat_next = ackok_reg ? `TWSM_ST_MRSA : `TWSM_ST_MRSN;
            else
              stat_next = ackok_reg ? `TWSM_ST_MTSA : `TWSM_ST_MTSN;
          end else if (tx_reg) begin
            stat_next = ackok_reg ? `TWSM_ST_MTDA : `TWSM_ST_MTDN;
          end else begin
            stat_next = ackd_reg ? `TWSM_ST_MRDA : `TWSM_ST_MRDN;
          end
        end else if (addr_reg & ackd_reg) begin
          eng_next = 1'h1;
          tx_next  = shift_reg[0];
          si_next  = 1'h1;
          if (shift_reg[0])
            stat_next = `TWSM_ST_STSLA;
          else
            stat_next = (shift_reg[7:1] == 7'h0) ? `TWSM_ST_SRGC : `TWSM_ST_SRSLA;
        end else if (eng_reg) begin
          si_next = 1'h1;
          if (tx_reg) begin
            stat_next = ackok_reg ? `TWSM_ST_STDA : `TWSM_ST_STDN;
            eng_next  = ackok_reg;
            tx_next   = ackok_reg;
          end else begin
            stat_next = ackd_reg ? `TWSM_ST_SRDA : `TWSM_ST_SRDN;
          end
        end else if (arbl_reg) begin
          si_next   = 1'h1;
          stat_next = `TWSM_ST_ARB;
          arbl_next = 1'h0;
        end
      end else begin
        cnt_next = cnt_reg + 4'h1;
      end
    end
    // Slave use of the stop request acts as a received STOP, bus stays busy
    if (~master_on & sto_reg) begin
      sto_next = 1'h0;
      eng_next = 1'h0;
      tx_next  = 1'h0;
    end
    // Data line is only changed while the clock is low
    sda_oe_next = sda_oe_reg;
    if (~scl_s) begin
      sda_oe_next = 1'h0;
      if (tx_reg & (cnt_reg < 4'h8) & ~si_reg)
        sda_oe_next = ~shift_reg[7];
      else if (~tx_reg & (cnt_reg == 4'h8))
        sda_oe_next = ackd_reg;
    end
    scl_oe_next = si_reg & ~scl_s;
    // Master sequencer; the clock is only ever pulled low or released
    unique case (mst_reg)
      m_idle: begin
        if (en_reg & sta_reg & ~busy_reg) begin
          mst_next  = m_start;
          tcnt_next = 10'h0;
          rs_next   = 1'h0;
        end
      end
      m_start: begin
        sda_oe_next = 1'h1;
        tcnt_next   = tcnt_reg + 10'h1;
        if (half_done) begin
          scl_oe_next = 1'h1;
          si_next     = 1'h1;
          stat_next   = rs_reg ? `TWSM_ST_RSTART : `TWSM_ST_START;
          sta_next    = 1'h0;
          mst_next    = m_run;
          sclhi_next  = 1'h0;
          tcnt_next   = 10'h0;
        end
      end
      m_run: begin
        if (~sclhi_reg) begin
          scl_oe_next = 1'h1;
          if (~si_reg) begin
            if ((cnt_reg == 4'h0) & sto_reg) begin
              mst_next  = m_stopl;
              tcnt_next = 10'h0;
            end else if ((cnt_reg == 4'h0) & sta_reg & ~addr_reg) begin
              mst_next  = m_rsl;
              tcnt_next = 10'h0;
            end else if (half_done) begin
              scl_oe_next = 1'h0;
              sclhi_next  = 1'h1;
              tcnt_next   = 10'h0;
            end else begin
              tcnt_next = tcnt_reg + 10'h1;
            end
          end
        end else if (scl_s) begin
          // High phase is timed only from the real rising level
          if (half_done) begin
            scl_oe_next = 1'h1;
            sclhi_next  = 1'h0;
            tcnt_next   = 10'h0;
          end else begin
            tcnt_next = tcnt_reg + 10'h1;
          end
        end
      end
      m_stopl: begin
        scl_oe_next = 1'h1;
        sda_oe_next = 1'h1;
        tcnt_next   = tcnt_reg + 10'h1;
        if (half_done) begin
          mst_next  = m_stopr;
          tcnt_next = 10'h0;
        end
      end
      m_stopr: begin
        scl_oe_next = 1'h0;
        sda_oe_next = 1'h1;
        if (scl_s) begin
          tcnt_next = tcnt_reg + 10'h1;
          if (half_done) begin
            mst_next  = m_stope;
            tcnt_next = 10'h0;
          end
        end
      end
      m_stope: begin
        sda_oe_next = 1'h0;
        tcnt_next   = tcnt_reg + 10'h1;
        if (half_done) begin
          mst_next  = m_idle;
          tcnt_next = 10'h0;
        end
      end
      m_rsl: begin
        scl_oe_next = 1'h1;
        sda_oe_next = 1'h0;
        tcnt_next   = tcnt_reg + 10'h1;
        if (half_done) begin
          mst_next  = m_rsr;
          tcnt_next = 10'h0;
        end
      end
      m_rsr: begin
        scl_oe_next = 1'h0;
        sda_oe_next = 1'h0;
        if (scl_s) begin
          tcnt_next = tcnt_reg + 10'h1;
          if (half_done) begin
            mst_next  = m_start;
            rs_next   = 1'h1;
            tcnt_next = 10'h0;
          end
        end
      end
    endcase
    // Clock-low watchdog; recovery takes effect on the very next edge
    if (en_reg & ~scl_s)
      lowc_next = lowc_reg + 22'h1;
    if (lowto_hit | ~en_reg) begin
      mst_next    = m_idle;
      eng_next    = 1'h0;
      tx_next     = 1'h0;
      arbl_next   = 1'h0;
      busy_next   = 1'h0;
      scl_oe_next = 1'h0;
      sda_oe_next = 1'h0;
      lowc_next   = 22'h0;
    end
    if (lowto_hit)
      to_next = 1'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_reg    <= m_idle;
      tcnt_reg   <= 10'h0;
      sclhi_reg  <= 1'h0;
      rs_reg     <= 1'h0;
      en_reg     <= 1'h0;
      sta_reg    <= 1'h0;
      sto_reg    <= 1'h0;
      si_reg     <= 1'h0;
      aa_reg     <= 1'h0;
      to_reg     <= 1'h0;
      busy_reg   <= 1'h0;
      own_reg    <= 8'h0;
      shift_reg  <= 8'h0;
      stat_reg   <= `TWSM_ST_IDLE;
      cnt_reg    <= 4'h0;
      tx_reg     <= 1'h0;
      addr_reg   <= 1'h0;
      eng_reg    <= 1'h0;
      ackd_reg   <= 1'h0;
      ackok_reg  <= 1'h0;
      arbl_reg   <= 1'h0;
      lowc_reg   <= 22'h0;
      freec_reg  <= 13'h0;
      scl_oe_reg <= 1'h0;
      sda_oe_reg <= 1'h0;
    end else begin
      mst_reg    <= mst_next;
      tcnt_reg   <= tcnt_next;
      sclhi_reg  <= sclhi_next;
      rs_reg     <= rs_next;
      en_reg     <= en_next;
      sta_reg    <= sta_next;
      sto_reg    <= sto_next;
      si_reg     <= si_next;
      aa_reg     <= aa_next;
      to_reg     <= to_next;
      busy_reg   <= busy_next;
      own_reg    <= own_next;
      shift_reg  <= shift_next;
      stat_reg   <= stat_next;
      cnt_reg    <= cnt_next;
      tx_reg     <= tx_next;
      addr_reg   <= addr_next;
      eng_reg    <= eng_next;
      ackd_reg   <= ackd_next;
      ackok_reg  <= ackok_next;
      arbl_reg   <= arbl_next;
      lowc_reg   <= lowc_next;
      freec_reg  <= freec_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  // Lines are never driven high: the output value is a constant-low flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_o <= 1'h0;
      sda_o <= 1'h0;
    end else begin
      scl_o <= 1'h0;
      sda_o <= 1'h0;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign scl_oe  = scl_oe_reg;
  assign sda_oe  = sda_oe_reg;

  // Checks on the engine and sequencer
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_si_hold;
    si_reg && !scl_s && en_reg && !lowto_hit |=> scl_oe_reg;
  endproperty
  a_si_hold: assert property (p_si_hold) else $error("clock not held while flag set");

  property p_start_flag;
    mst_reg == m_start && half_done && en_reg && !lowto_hit |=>
      si_reg && scl_oe_reg && (stat_reg == `TWSM_ST_START || stat_reg == `TWSM_ST_RSTART);
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("start did not raise flag");

  property p_idle_code;
    acc && reg_hit(paddr, `TWSM_OFS_STAT) && !si_reg |=> prdata_reg[7:0] == `TWSM_ST_IDLE;
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("idle code wrong");

  property p_free;
    busy_reg && scl_s && sda_s && freec_reg == FREE_CYC - 13'h1 && !start_det |=> !busy_reg;
  endproperty
  a_free: assert property (p_free) else $error("bus not freed after idle time");

  property p_lowto;
    lowto_hit |=> to_reg && mst_reg == m_idle && !sda_oe_reg && !scl_oe_reg ##1 !scl_oe_reg;
  endproperty
  a_lowto: assert property (p_lowto) else $error("timeout did not reset link");

  property p_arb;
    rise && !start_det && tx_reg && cnt_reg < 4'h8 && !sda_oe_reg && !sda_s && en_reg
      && !lowto_hit |=> !tx_reg && arbl_reg && mst_reg == m_idle;
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration loss missed");

  property p_ack_drive;
    !scl_s && !tx_reg && cnt_reg == 4'h8 && ackd_reg && en_reg && !lowto_hit
      && (mst_reg == m_idle || mst_reg == m_run) |=> sda_oe_reg;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

  property p_stretch;
    mst_reg == m_run && sclhi_reg && !scl_s && en_reg && !lowto_hit |=>
      tcnt_reg == $past(tcnt_reg) && !scl_oe_reg;
  endproperty
  a_stretch: assert property (p_stretch) else $error("master ran on while clock held");

  property p_stop_order;
    mst_reg == m_stopr && !scl_s && en_reg && !lowto_hit |=> sda_oe_reg && !scl_oe_reg;
  endproperty
  a_stop_order: assert property (p_stop_order) else $error("stop released data early");
endmodule : twsm_top
`default_nettype wire

// >>> include/twsm_cfg.svh
// Purpose: constants for the two-wire serial master/slave port
// Assumes: pclk runs at 125 MHz, APB registers one 32-bit word each
// Notes: times kept in their own unit, cycle counts derived from them
// What this block does
// - Software moves whole bytes; hardware sequences every serial bit itself.
// - Works as master, slave or both on a multi-master bus.
// - First byte after START holds 7-bit address over the direction bit.
// - Direction one reads from slave; direction zero writes to slave.
// - Receiver acknowledges by holding data low during the clock-high phase.
// - Master transmitter sends START, address with write, data, checks each ack.
// - Master ends every transaction with a STOP, freeing the bus.
// - Master starts only on a free bus: after STOP or idle-high time.
// - Losing arbitration drops master role and keeps receiving as slave.
// - Master waits for the clock line really high before continuing.
// - Clock held low beyond 25 ms counts as a timeout.
// - After that timeout, bus communication is reset within 10 ms.
// - Both lines high beyond 50 us marks the bus free without STOP.
// - A pending START is issued once the bus-free timeout expires.
// - Transfer mode is one of four and reported by status code.
// - Master receiver clocks data and acks per assert-acknowledge setting.
// - Slave acknowledges an address equal to its own-address register.
// - Slave acknowledges general call only when own-address bit zero is set.
// - Slave transmitter sends on master clock, checks ack, leaves on STOP.
// - Whoever sends START plus address is master for that transfer.
// - Interrupt flag sets on every protocol state except idle; software clears.
// - With interrupt flag set and clock low, clock stays held low.
// - Assert-acknowledge one acks when addressed; zero nacks and ignores addresses.
// - STOP and START requested together give STOP first, then START.
`ifndef TWSM_CFG_SVH
`define TWSM_CFG_SVH
`define TWSM_CLK_NS     8
`define TWSM_HALF_NS    5000
`define TWSM_HALF_CYC   ((`TWSM_HALF_NS + `TWSM_CLK_NS - 1) / `TWSM_CLK_NS)
`define TWSM_LOWTO_MS   25
`define TWSM_LOWTO_CYC  ((`TWSM_LOWTO_MS * 1000000) / `TWSM_CLK_NS)
`define TWSM_FREE_US    50
`define TWSM_FREE_CYC   ((`TWSM_FREE_US * 1000 + `TWSM_CLK_NS - 1) / `TWSM_CLK_NS)
`define TWSM_OFS_CTRL   8'h00
`define TWSM_OFS_DATA   8'h04
`define TWSM_OFS_ADDR   8'h08
`define TWSM_OFS_STAT   8'h0C
`define TWSM_B_BUSY     7
`define TWSM_B_EN       6
`define TWSM_B_STA      5
`define TWSM_B_STO      4
`define TWSM_B_SI       3
`define TWSM_B_AA       2
`define TWSM_B_TO       0
`define TWSM_ST_START   8'h08
`define TWSM_ST_RSTART  8'h10
`define TWSM_ST_MTSA    8'h18
`define TWSM_ST_MTSN    8'h20
`define TWSM_ST_MTDA    8'h28
`define TWSM_ST_MTDN    8'h30
`define TWSM_ST_ARB     8'h38
`define TWSM_ST_MRSA    8'h40
`define TWSM_ST_MRSN    8'h48
`define TWSM_ST_MRDA    8'h50
`define TWSM_ST_MRDN    8'h58
`define TWSM_ST_SRSLA   8'h60
`define TWSM_ST_SRGC    8'h70
`define TWSM_ST_SRDA    8'h80
`define TWSM_ST_SRDN    8'h88
`define TWSM_ST_SRSTOP  8'hA0
`define TWSM_ST_STSLA   8'hA8
`define TWSM_ST_STDA    8'hB8
`define TWSM_ST_STDN    8'hC0
`define TWSM_ST_IDLE    8'hF8
`endif

// >>> include/twsm_pkg.sv
// Purpose: types for the two-wire serial master/slave port
// Assumes: nothing beyond the config header
// Notes: master sequencer states
package twsm_pkg;
  typedef enum logic [2:0] {
    m_idle  = 3'b000,
    m_start = 3'b001,
    m_run   = 3'b010,
    m_stopl = 3'b011,
    m_stopr = 3'b100,
    m_stope = 3'b101,
    m_rsl   = 3'b110,
    m_rsr   = 3'b111
  } twsm_mst_t;
endpackage : twsm_pkg

// >>> tb/twsm_slave_model.sv
// Purpose: behavioural target device on the two-wire bus
// Assumes: lines are open drain with pull-ups resolved in the bench
// Notes: acks its own write address and each data byte that follows it; cannot transmit
`timescale 1ns/1ps
`default_nettype none
module twsm_slave_model #(
  parameter logic [6:0] ADDR = 7'h5A
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       hold_scl,
  output logic            sda_pull,
  output logic            scl_pull,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh;
  logic       hit;
  logic       first;
  int         n;
  // Stretching the low phase by holding the clock line
  assign scl_pull = hold_scl;
  initial begin
    sda_pull = 1'b0;
    rx_byte  = 8'h00;
    hit      = 1'b0;
    first    = 1'b0;
    sh       = 8'h00;
    n        = 0;
  end
  // Bus conditions restart the bit counter
  always @(negedge sda) if (scl === 1'b1) begin
    n     = 0;
    first = 1'b1;
    hit   = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    n   = 0;
    hit = 1'b0;
  end
  // Bits are taken MSB first while the clock is high
  always @(posedge scl) if (n < 8) begin
    sh = {sh[6:0], sda};
    n  = n + 1;
  end
  // Ack slot: pull data low only when addressed, release after it
  always @(negedge scl) begin
    if (n == 8) begin
      if (first) hit = (sh[7:1] == ADDR) && !sh[0];
      else rx_byte = sh;
      first    = 1'b0;
      sda_pull <= hit;
      n        = 9;
    end else if (n == 9) begin
      sda_pull <= 1'b0;
      n        = 0;
    end
  end
endmodule : twsm_slave_model
`default_nettype wire

// >>> tb/tb_two_wire_serial_master_slave.sv
// Purpose: self-checking bench for the two-wire master/slave port
// Assumes: short timeout counts so the clock-low case runs fast
// Notes: master role only; the partner cannot send data back
`timescale 1ns/1ps
`default_nettype none
`include "twsm_cfg.svh"
module tb_two_wire_serial_master_slave;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, rx_byte;
  logic [31:0] pwdata, prdata, r;
  logic        scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull, hold_scl, e, sda_ext;
  wire         scl_w = !(scl_oe | scl_pull);
  wire         sda_w = !(sda_oe | sda_pull | sda_ext);
  int          n_fail, total_checks;
  twsm_top #(.LOWTO_CYC(22'd1000), .FREE_CYC(13'd700)) u_twsm_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
  twsm_slave_model u_twsm_slave_model (.scl(scl_w), .sda(sda_w), .hold_scl(hold_scl),
    .sda_pull(sda_pull), .scl_pull(scl_pull), .rx_byte(rx_byte));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_fail++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Poll control until a bit reaches the wanted level, bounded
  task automatic poll(input int b, input logic v);
    int k;
    k = 0;
    do begin apb(1'b0, `TWSM_OFS_CTRL, 32'h0); k++; end while (r[b] !== v && k < 6000);
    if (r[b] !== v) n_fail++;
  endtask : poll
  // Send one byte and release the held clock by clearing the flag
  task automatic send(input logic [7:0] b, input logic [7:0] st);
    apb(1'b1, `TWSM_OFS_DATA, {24'h0, b});
    apb(1'b1, `TWSM_OFS_CTRL, 32'h44);
    poll(`TWSM_B_SI, 1'b1);
    apb(1'b0, `TWSM_OFS_STAT, 32'h0);
    chk("status", r, {24'h0, st});
  endtask : send
  task automatic t_regs;
    apb(1'b0, `TWSM_OFS_CTRL, 32'h0);
    chk("ctrl reset", r, 32'h0);
    apb(1'b0, `TWSM_OFS_STAT, 32'h0);
    chk("idle status", r, 32'h0000_00F8);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
    apb(1'b1, `TWSM_OFS_ADDR, 32'hA5);
    apb(1'b0, `TWSM_OFS_ADDR, 32'h0);
    chk("own address", r, 32'h0000_00A5);
  endtask : t_regs
  // Start, address, optional data byte, then stop and a free bus
  task automatic t_write(input logic [6:0] a, input logic [7:0] ast);
    apb(1'b1, `TWSM_OFS_CTRL, 32'h64);
    poll(`TWSM_B_SI, 1'b1);
    apb(1'b0, `TWSM_OFS_STAT, 32'h0);
    chk("start status", r, {24'h0, `TWSM_ST_START});
    send({a, 1'b0}, ast);
    if (ast == `TWSM_ST_MTSA) begin
      send(8'h3C, `TWSM_ST_MTDA);
      chk("byte seen", {24'h0, rx_byte}, 32'h3C);
    end
    apb(1'b1, `TWSM_OFS_CTRL, 32'h54);
    poll(`TWSM_B_BUSY, 1'b0);
    chk("stop cleared", {31'h0, r[`TWSM_B_STO]}, 32'h0);
    chk("lines idle", {30'h0, scl_w, sda_w}, 32'h3);
    chk("drive level", {30'h0, scl_o, sda_o}, 32'h0);
  endtask : t_write
  // Far side holds the clock low past the limit
  task automatic t_timeout;
    apb(1'b1, `TWSM_OFS_CTRL, 32'h64);
    poll(`TWSM_B_SI, 1'b1);
    hold_scl <= 1'b1;
    apb(1'b1, `TWSM_OFS_DATA, 32'hB4);
    apb(1'b1, `TWSM_OFS_CTRL, 32'h44);
    repeat (1100) @(posedge pclk);
    apb(1'b0, `TWSM_OFS_CTRL, 32'h0);
    chk("timeout bit", {31'h0, r[`TWSM_B_TO]}, 32'h1);
    chk("busy after timeout", {31'h0, r[`TWSM_B_BUSY]}, 32'h0);
    chk("lines let go", {30'h0, scl_oe, sda_oe}, 32'h0);
    hold_scl <= 1'b0;
  endtask : t_timeout
  // Foreign START with no STOP keeps the bus busy; a pending START waits out the idle time
  task automatic t_free;
    repeat (20) @(posedge pclk);
    sda_ext <= 1'b1;
    repeat (20) @(posedge pclk);
    hold_scl <= 1'b1;
    repeat (20) @(posedge pclk);
    sda_ext <= 1'b0;
    repeat (20) @(posedge pclk);
    hold_scl <= 1'b0;
    apb(1'b1, `TWSM_OFS_CTRL, 32'h64);
    apb(1'b0, `TWSM_OFS_CTRL, 32'h0);
    chk("busy before free", {31'h0, r[`TWSM_B_BUSY]}, 32'h1);
    chk("start held back", {31'h0, r[`TWSM_B_SI]}, 32'h0);
    poll(`TWSM_B_SI, 1'b1);
    apb(1'b0, `TWSM_OFS_STAT, 32'h0);
    chk("start after idle", r, {24'h0, `TWSM_ST_START});
    apb(1'b1, `TWSM_OFS_CTRL, 32'h54);
    poll(`TWSM_B_BUSY, 1'b0);
  endtask : t_free
  task automatic finish_test;
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    finish_test();
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; hold_scl = 1'b0; sda_ext = 1'b0;
    n_fail = 0; total_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    apb(1'b1, `TWSM_OFS_ADDR, 32'h0);
    t_write(7'h5A, `TWSM_ST_MTSA);
    t_write(7'h22, `TWSM_ST_MTSN);
    t_timeout();
    t_free();
    finish_test();
  end
endmodule : tb_two_wire_serial_master_slave
`default_nettype wire
